// [hw/tag_round_pkg.sv]
// Shared types and constants for the tag round command interpreter.
// Assumes a framer that has already decoded and CRC-checked each short command.
package tag_round_pkg;

  // Short command frame, first bit received at the top
  typedef struct packed {
    logic ext;
    logic [5:0] code;
    logic [3:0] arg;
    logic [4:0] crc;
  } frame_t;

  // Reply handed to the encoder; preamble and CRC-16 are added there
  typedef struct packed {
    logic isError;
    logic [3:0] errCode;
    logic suidFlag;
    logic [1:0] flags;
    logic tagType;
    logic battery;
    logic [3:0] signature;
    logic [7:0] idByte;
    logic [127:0] payload;
    logic [7:0] payloadBits;
  } reply_t;

  typedef enum logic [2:0] {
    ST_READY = 3'b000,
    ST_QUIET = 3'b001,
    ST_SELECTED = 3'b010,
    ST_LIVE = 3'b011,
    ST_PAUSED = 3'b100
  } tag_state_t;

  localparam logic [5:0] CODE_ROUND_FILTERED = 6'h01;
  localparam logic [5:0] CODE_SLOT_ADVANCE = 6'h02;
  localparam logic [5:0] CODE_SLOT_CLOSE = 6'h03;
  localparam logic [5:0] CODE_STANDBY = 6'h04;
  localparam logic [5:0] CODE_NEW_ROUND = 6'h05;
  localparam logic [5:0] CODE_RETURN_TO_IDLE = 6'h06;
  localparam logic [5:0] CODE_ROUND_ALL = 6'h0a;

  localparam logic [7:0] FAMILY_ALL = 8'h00;
  localparam logic [3:0] ERR_UNSUPPORTED = 4'h1;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [7:0] SHORT_UNIQUE_IDENTIFIER_BITS = 8'h28;
  localparam logic [7:0] PAGE_BITS = 8'h20;

  // Register word offsets (byte address = 4 * index)
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_SHORT_UNIQUE_IDENTIFIER_LO = 4'h1;
  localparam logic [3:0] REG_SHORT_UNIQUE_IDENTIFIER_HI = 4'h2;
  localparam logic [3:0] REG_USER0 = 4'h3;
  localparam logic [3:0] REG_USER3 = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_RANDOM = 4'h8;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0004;
  localparam logic [7:0] LFSR_SEED_SLOT = 8'h5a;
  localparam logic [3:0] LFSR_SEED_SIG = 4'h9;
  localparam logic [15:0] LFSR_SEED_RAND = 16'hace1;

endpackage : tag_round_pkg

// [hw/tag_round_reset_and_start.sv]
// Command interpreter for return-to-idle, unfiltered round start, slot advance, standby and unsupported commands.
// Assumes frames arrive on core_clk from an on-chip framer; registers sit on an Avalon-MM slave.
//
// Function
// - Return-to-idle frame: extension bit, code 06, four zero reserved bits, 5-bit CRC.
// - Return-to-idle clears all stored parameters, family identifier and slot counter included.
// - Return-to-idle moves every state to ready and sends no reply.
// - Return-to-idle also clears the persistent silenced indication.
// - Code 0A starts a round with family identifier 00, matching every family.
// - Round start frame: extension, code, short-identifier flag, 3-bit round size, CRC.
// - Flag clear reply: flags, type, battery, signature, random byte, memory page.
// - Flag set reply: flags, type, battery, signature, storage format, 40-bit short identifier.
// - A round start received with an error gets no reply.
// - Memory field carries leading user data up to 128 bits, else short identifier.
// - Signature and random byte come from independent generators.
// - Tag-type bit is 0 without battery assistance, 1 with it.
// - Battery bit is 1 when good, 0 when low, always 0 unassisted.
// - Ready tag on round start picks random slot, counter to 1, goes live.
// - Silenced tag ignores round start, stays silent and silenced.
// - Selected tag ignores round start and becomes silenced.
// - Live or paused tag re-picks random slot and reloads counter with 1.
// - Slots run from 1 to round size; random choice stays in range.
// - Selected tag answers unimplemented optional command with error code 1.
// - Tag matching a carried short identifier answers unimplemented command with error 1.
// - All other tags stay silent on unimplemented optional commands.
// - In a round, slot advance increments counter; reply only when it equals slot.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns

module tag_round_reset_and_start
  import tag_round_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic frameValid,
  input wire frame_t frame,
  input wire logic frameErr,
  input wire logic frameHasSuid,
  input wire logic [39:0] frameSuid,
  output logic replyValid,
  output reply_t reply,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  tag_state_t state_q;
  tag_state_t state_d;
  logic quietMem_q;
  logic [3:0] slotCounter_q;
  logic [3:0] chosenSlot_q;
  logic [3:0] roundSize_q;
  logic suidFlag_q;
  logic answered_q;
  logic [7:0] family_q;
  logic [31:0] config_q;
  logic [39:0] short_unique_identifier_q;
  logic [127:0] user_q;
  logic [7:0] lfsrSlot_q;
  logic [3:0] lfsrSig_q;
  logic [15:0] lfsrRand_q;
  logic ack_q;
  // Signature sent in the last reply, kept so a later acknowledgement can match it
  logic [3:0] sigHeld_q;

  logic frameOk;
  logic isIdle;
  logic isStart;
  logic isAdvance;
  logic isStandby;
  logic isKnown;
  logic isOptional;
  logic sigMatch;
  logic ackedHere;
  logic [3:0] sizeCmd;
  logic [3:0] pickSlot;
  logic [3:0] nextCount;
  logic startTaken;
  logic advanceTaken;
  logic sendRound;
  logic sendError;

  // Config fields
  logic cfgAssisted;
  logic cfgBattGood;
  logic cfgHasMem;
  logic [1:0] cfgPage;
  logic [7:0] cfgFormat;

  assign cfgAssisted = config_q[0];
  assign cfgBattGood = config_q[1];
  assign cfgHasMem = config_q[2];
  assign cfgPage = config_q[4:3];
  assign cfgFormat = config_q[15:8];

  // A set extension bit means a longer frame this block cannot parse, so it is dropped
  assign frameOk = frameValid && !frameErr && !frame.ext;
  assign isIdle = frameOk && frame.code == CODE_RETURN_TO_IDLE;
  assign isStart = frameOk && frame.code == CODE_ROUND_ALL;
  assign isAdvance = frameOk && (frame.code == CODE_SLOT_ADVANCE || frame.code == CODE_SLOT_CLOSE);
  assign isStandby = frameOk && frame.code == CODE_STANDBY;
  assign isKnown = frame.code == CODE_ROUND_FILTERED || frame.code == CODE_SLOT_ADVANCE ||
                   frame.code == CODE_SLOT_CLOSE || frame.code == CODE_STANDBY ||
                   frame.code == CODE_NEW_ROUND || frame.code == CODE_RETURN_TO_IDLE ||
                   frame.code == CODE_ROUND_ALL;
  assign isOptional = frameOk && !isKnown;
  // Close carries reserved bits, not a signature, so it never acknowledges
  assign sigMatch = frame.arg == sigHeld_q;
  assign ackedHere = state_q == ST_LIVE && answered_q && sigMatch;

  // Size 0 would give an empty round; treat it as a single slot
  assign sizeCmd = (frame.arg[2:0] == 3'h0) ? 4'h1 : {1'b0, frame.arg[2:0]};
  assign pickSlot = 4'(lfsrSlot_q % 8'(sizeCmd)) + SLOT_FIRST;
  assign nextCount = slotCounter_q + 4'h1;

  assign startTaken = isStart && (state_q == ST_READY || state_q == ST_LIVE || state_q == ST_PAUSED);
  assign advanceTaken = isAdvance && (state_q == ST_PAUSED || (state_q == ST_LIVE &&
                        !(frame.code == CODE_SLOT_ADVANCE && ackedHere)));
  assign sendRound = (startTaken && pickSlot == SLOT_FIRST) ||
                     (advanceTaken && nextCount == chosenSlot_q);
  assign sendError = isOptional && (state_q == ST_SELECTED ||
                     (frameHasSuid && frameSuid == short_unique_identifier_q));

  always_comb begin
    state_d = state_q;
    if (isIdle) begin
      state_d = ST_READY;
    end else if (isStart) begin
      case (state_q)
        ST_READY: state_d = ST_LIVE;
        ST_QUIET: state_d = ST_QUIET;
        ST_SELECTED: state_d = ST_QUIET;
        ST_LIVE: state_d = ST_LIVE;
        ST_PAUSED: state_d = ST_LIVE;
        default: state_d = ST_READY;
      endcase
    end else if (isAdvance) begin
      case (state_q)
        ST_SELECTED: state_d = ST_QUIET;
        ST_LIVE: state_d = (frame.code == CODE_SLOT_ADVANCE && ackedHere) ? ST_QUIET : ST_LIVE;
        ST_PAUSED: state_d = ST_LIVE;
        default: state_d = state_q;
      endcase
    end else if (isStandby) begin
      case (state_q)
        ST_SELECTED: state_d = ST_QUIET;
        ST_LIVE: state_d = ackedHere ? ST_SELECTED : ST_PAUSED;
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // Persistent silenced memory survives until return-to-idle or power loss
  always_ff @(posedge core_clk) begin
    if (srst || isIdle) begin
      quietMem_q <= 1'b0;
    end else if (state_d == ST_QUIET) begin
      quietMem_q <= 1'b1;
    end
  end

  // Round parameters
  always_ff @(posedge core_clk) begin
    if (srst || isIdle) begin
      slotCounter_q <= 4'h0;
      chosenSlot_q <= 4'h0;
      roundSize_q <= 4'h0;
      suidFlag_q <= 1'b0;
      answered_q <= 1'b0;
      family_q <= FAMILY_ALL;
      sigHeld_q <= 4'h0;
    end else if (startTaken) begin
      slotCounter_q <= SLOT_FIRST;
      chosenSlot_q <= pickSlot;
      roundSize_q <= sizeCmd;
      suidFlag_q <= frame.arg[3];
      family_q <= FAMILY_ALL;
      answered_q <= pickSlot == SLOT_FIRST;
      sigHeld_q <= lfsrSig_q;
    end else if (advanceTaken) begin
      // Counter saturates so a long round cannot wrap back onto the chosen slot
      slotCounter_q <= (slotCounter_q == 4'hf) ? slotCounter_q : nextCount;
      answered_q <= nextCount == chosenSlot_q;
      if (nextCount == chosenSlot_q) begin
        sigHeld_q <= lfsrSig_q;
      end
    end
  end

  // Three separate generators keep slot, signature and random byte independent
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lfsrSlot_q <= LFSR_SEED_SLOT;
      lfsrSig_q <= LFSR_SEED_SIG;
      lfsrRand_q <= LFSR_SEED_RAND;
    end else begin
      lfsrSlot_q <= {lfsrSlot_q[6:0], lfsrSlot_q[7] ^ lfsrSlot_q[5] ^ lfsrSlot_q[4] ^ lfsrSlot_q[3]};
      lfsrSig_q <= {lfsrSig_q[2:0], lfsrSig_q[3] ^ lfsrSig_q[2]};
      lfsrRand_q <= {lfsrRand_q[14:0], lfsrRand_q[15] ^ lfsrRand_q[13] ^ lfsrRand_q[12] ^ lfsrRand_q[10]};
    end
  end

  // Reply builder
  logic useSuid;
  assign useSuid = (startTaken ? frame.arg[3] : suidFlag_q);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      replyValid <= 1'b0;
      reply <= '0;
    end else begin
      replyValid <= sendRound || sendError;
      if (sendError) begin
        reply <= '0;
        reply.isError <= 1'b1;
        reply.errCode <= ERR_UNSUPPORTED;
        reply.flags <= 2'b01;
      end else if (sendRound) begin
        reply.isError <= 1'b0;
        reply.errCode <= 4'h0;
        reply.suidFlag <= useSuid;
        reply.flags <= 2'b00;
        reply.tagType <= cfgAssisted;
        reply.battery <= cfgAssisted && cfgBattGood;
        reply.signature <= lfsrSig_q;
        if (useSuid) begin
          reply.idByte <= cfgFormat;
          reply.payload <= {88'h0, short_unique_identifier_q};
          reply.payloadBits <= SHORT_UNIQUE_IDENTIFIER_BITS;
        end else begin
          reply.idByte <= lfsrRand_q[7:0];
          if (cfgHasMem) begin
            reply.payload <= user_q;
            reply.payloadBits <= 8'(PAGE_BITS * ({6'h0, cfgPage} + 8'h1));
          end else begin
            reply.payload <= {88'h0, short_unique_identifier_q};
            reply.payloadBits <= SHORT_UNIQUE_IDENTIFIER_BITS;
          end
        end
      end
    end
  end

  // Avalon slave: one wait cycle, then answer at the edge where waitrequest is low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      config_q <= CONFIG_RESET;
      short_unique_identifier_q <= 40'h0;
      user_q <= 128'h0;
    end else if (avs_write && ack_q) begin
      case (avs_address)
        REG_CONFIG: config_q <= {16'h0, avs_writedata[15:0]};
        REG_SHORT_UNIQUE_IDENTIFIER_LO: short_unique_identifier_q[31:0] <= avs_writedata;
        REG_SHORT_UNIQUE_IDENTIFIER_HI: short_unique_identifier_q[39:32] <= avs_writedata[7:0];
        4'h3: user_q[127:96] <= avs_writedata;
        4'h4: user_q[95:64] <= avs_writedata;
        4'h5: user_q[63:32] <= avs_writedata;
        REG_USER3: user_q[31:0] <= avs_writedata;
        default: config_q <= config_q;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        REG_CONFIG: avs_readdata <= config_q;
        REG_SHORT_UNIQUE_IDENTIFIER_LO: avs_readdata <= short_unique_identifier_q[31:0];
        REG_SHORT_UNIQUE_IDENTIFIER_HI: avs_readdata <= {24'h0, short_unique_identifier_q[39:32]};
        REG_USER0: avs_readdata <= user_q[127:96];
        4'h4: avs_readdata <= user_q[95:64];
        4'h5: avs_readdata <= user_q[63:32];
        REG_USER3: avs_readdata <= user_q[31:0];
        REG_STATUS: avs_readdata <= {family_q, 2'h0, answered_q, suidFlag_q, roundSize_q,
                                     chosenSlot_q, slotCounter_q, 4'h0, quietMem_q, state_q};
        REG_RANDOM: avs_readdata <= {20'h0, lfsrSig_q, lfsrRand_q[7:0]};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  idle_state_a: assert property (isIdle |=> state_q == ST_READY && !quietMem_q)
    else $error("return-to-idle did not reach ready");
  idle_clear_a: assert property (isIdle |=> slotCounter_q == 4'h0 && chosenSlot_q == 4'h0 && family_q == 8'h00)
    else $error("return-to-idle left parameters set");
  idle_silent_a: assert property (isIdle |=> !replyValid)
    else $error("reply after return-to-idle");
  error_drop_a: assert property (frameValid && frameErr |=> !replyValid)
    else $error("reply to errored frame");
  ready_start_a: assert property (isStart && state_q == ST_READY |=> state_q == ST_LIVE && slotCounter_q == 4'h1)
    else $error("ready tag did not start round");
  quiet_ignore_a: assert property (isStart && state_q == ST_QUIET |=> state_q == ST_QUIET && !replyValid)
    else $error("silenced tag reacted to round start");
  selected_quiet_a: assert property (isStart && state_q == ST_SELECTED |=> state_q == ST_QUIET)
    else $error("selected tag not silenced");
  round_restart_a: assert property (isStart && (state_q == ST_LIVE || state_q == ST_PAUSED)
                                    |=> state_q == ST_LIVE && slotCounter_q == 4'h1)
    else $error("round restart failed");
  slot_range_a: assert property (state_q == ST_LIVE |-> chosenSlot_q >= 4'h1 && chosenSlot_q <= roundSize_q)
    else $error("chosen slot out of range");
  unsup_error_a: assert property (isOptional && state_q == ST_SELECTED
                                  |=> replyValid && reply.isError && reply.errCode == 4'h1)
    else $error("missing unsupported-command error");
  type_bits_a: assert property (replyValid && !reply.isError
                                |-> reply.tagType == config_q[0] && (reply.battery -> reply.tagType))
    else $error("tag type or battery bit wrong");
  slot_send_a: assert property (replyValid && !reply.isError && state_q == ST_LIVE |-> slotCounter_q == chosenSlot_q)
    else $error("reply outside chosen slot");
  family_all_a: assert property (startTaken |=> family_q == FAMILY_ALL)
    else $error("round start left a family filter");
  // Saturation at the top is allowed, so the step is only checked below it
  slot_step_a: assert property (advanceTaken && slotCounter_q != 4'hf
                                |=> slotCounter_q == $past(slotCounter_q) + 4'h1)
    else $error("slot counter did not step");
  slot_hit_a: assert property (advanceTaken && nextCount == chosenSlot_q
                               |=> replyValid && !reply.isError)
    else $error("no reply in chosen slot");
  slot_miss_a: assert property (isAdvance && nextCount != chosenSlot_q
                                |=> !replyValid)
    else $error("reply outside chosen slot on advance");
  // The encoder trusts payloadBits, so the unused upper payload must stay clear
  short_unique_identifier_reply_a: assert property (replyValid && !reply.isError && reply.suidFlag
                                 |-> reply.idByte == cfgFormat && reply.payloadBits == SHORT_UNIQUE_IDENTIFIER_BITS &&
                                     reply.payload[127:40] == 88'h0)
    else $error("short-identifier reply malformed");
  page_cap_a: assert property (replyValid && !reply.isError
                               |-> reply.payloadBits <= 8'h80)
    else $error("memory field above 128 bits");
  round_flags_a: assert property (replyValid && !reply.isError |-> reply.flags == 2'b00)
    else $error("round reply flags set");
  error_code_a: assert property (replyValid && reply.isError
                                 |-> reply.errCode == ERR_UNSUPPORTED && reply.flags == 2'b01)
    else $error("wrong unsupported-command error");
  short_unique_identifier_match_a: assert property (isOptional && frameHasSuid && frameSuid == short_unique_identifier_q
                                 |=> replyValid && reply.isError)
    else $error("matching tag did not report unsupported command");
  optional_silent_a: assert property (isOptional && state_q != ST_SELECTED &&
                                      !(frameHasSuid && frameSuid == short_unique_identifier_q) |=> !replyValid)
    else $error("uninvolved tag answered optional command");
  quiet_memory_a: assert property (state_q == ST_QUIET |-> quietMem_q)
    else $error("silenced state without silenced memory");
  // The slave always inserts exactly one wait state
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  bus_release_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule : tag_round_reset_and_start

// [sim/interrogator_model.sv]
// Interrogator model: sends short command frames to the tag interpreter and watches its replies.
// Assumes the on-chip framer has already checked CRC-5, so the CRC field is sent as zero.
`timescale 1ns/1ns

module interrogator_model
  import tag_round_pkg::*;
(
  input wire logic core_clk,
  output logic frameValid,
  output frame_t frame,
  output logic frameErr,
  output logic frameHasSuid,
  output logic [39:0] frameSuid,
  input wire logic replyValid,
  input wire reply_t reply
);
  logic [11:0] collisionKey;

  initial begin
    frameValid = 1'h0;
    frame = '0;
    frameErr = 1'h0;
    frameHasSuid = 1'h0;
    frameSuid = '0;
  end

  // Signature and random byte together form one key for spotting identical-memory collisions
  always @(posedge core_clk) begin
    if (replyValid && !reply.isError && !reply.suidFlag) begin
      collisionKey <= {reply.signature, reply.idByte};
    end
  end

  task automatic send(input logic x, input logic [5:0] c, input logic [3:0] a, input logic e,
    input logic hs, input logic [39:0] s);
    @(posedge core_clk);
    frameValid <= 1'h1;
    frame <= {x, c, a, 5'h00};
    frameErr <= e;
    frameHasSuid <= hs;
    frameSuid <= s;
    @(posedge core_clk);
    // Released lines show no stale copy of the last frame
    frameValid <= 1'h0;
    frame <= ~frame;
    frameErr <= ~e;
    frameHasSuid <= ~hs;
    frameSuid <= ~s;
  endtask : send
endmodule : interrogator_model

// [sim/testbench.sv]
// Self-checking bench for the tag round command interpreter.
// Assumes the interrogator model drives frames; registers are reached over Avalon-MM.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin nMismatch++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module testbench;
  import tag_round_pkg::*;
  logic core_clk, srst, frameValid, frameErr, frameHasSuid, replyValid, rv;
  logic avsRead, avsWrite, avsWaitrequest, wrqPre;
  frame_t frame;
  reply_t reply;
  logic [39:0] frameSuid, short_unique_identifier;
  logic [3:0] avsAddress, sig;
  logic [31:0] avsWriteData, avsReadData, q, st, cfg, rdPre;
  logic [127:0] user;
  logic [7:0] sfid;
  int nMismatch, checkCount, size, ch;

  tag_round_reset_and_start i_tag_round_reset_and_start (.core_clk(core_clk), .srst(srst),
    .frameValid(frameValid), .frame(frame), .frameErr(frameErr), .frameHasSuid(frameHasSuid),
    .frameSuid(frameSuid), .replyValid(replyValid), .reply(reply), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWriteData),
    .avs_readdata(avsReadData), .avs_waitrequest(avsWaitrequest));

  interrogator_model i_interrogator_model (.core_clk(core_clk), .frameValid(frameValid), .frame(frame),
    .frameErr(frameErr), .frameHasSuid(frameHasSuid), .frameSuid(frameSuid),
    .replyValid(replyValid), .reply(reply));

  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  // Waitrequest and read data as the next rising edge will sample them
  always @(negedge core_clk) begin
    wrqPre = avsWaitrequest;
    rdPre = avsReadData;
  end

  task automatic conclude();
    if (nMismatch == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge core_clk);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wrqPre !== 1'h0 && n < 20);
    r = rdPre;
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
    if (n >= 20) begin
      nMismatch++;
      conclude();
    end
  endtask : xfer

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    xfer(1'h0, a, 32'h0, r);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'h1, a, d, r);
  endtask : wr

  task automatic cmd(input logic [5:0] c, input logic [3:0] a, input logic e, input logic hs,
    input logic [39:0] s, output logic v);
    i_interrogator_model.send(1'h0, c, a, e, hs, s);
    #1 v = replyValid;
  endtask : cmd

  task automatic rti();
    logic v;
    logic [31:0] s;
    cmd(CODE_RETURN_TO_IDLE, 4'h0, 1'h0, 1'h0, 40'h0, v);
    `CHK("idleReply", 1'h0, v)
    rd(REG_STATUS, s);
    `CHK("idleState", 4'h0, s[3:0])
    `CHK("idleParams", 12'h0, {s[31:24], s[11:8]})
  endtask : rti

  initial begin
    srst = 1'h1;
    avsRead = 1'h0;
    avsWrite = 1'h0;
    avsAddress = 4'h0;
    avsWriteData = 32'h0;
    nMismatch = 0;
    checkCount = 0;
    void'($urandom(32'hcfc86057));
    repeat (10) @(posedge core_clk);
    srst <= 1'h0;
    rd(REG_CONFIG, q);
    `CHK("configReset", CONFIG_RESET, q)
    rd(REG_STATUS, q);
    `CHK("stateReset", 3'h0, q[2:0])
    rd(4'hf, q);
    `CHK("unmapped", 32'h0, q)
    q = $urandom();
    wr(REG_SHORT_UNIQUE_IDENTIFIER_LO, q);
    short_unique_identifier[31:0] = q;
    q = $urandom();
    wr(REG_SHORT_UNIQUE_IDENTIFIER_HI, {24'h0, q[7:0]});
    short_unique_identifier[39:32] = q[7:0];
    for (int i = 0; i < 4; i++) begin
      q = $urandom();
      wr(REG_USER0 + 4'(i), q);
      user[127 - 32 * i -: 32] = q;
    end
    sfid = 8'($urandom());
    // Each pass: assisted/good bits and memory page size from the loop index
    for (int i = 0; i < 4; i++) begin
      cfg = {16'h0, sfid, 3'h0, 2'(i), 1'h1, 2'(i)};
      wr(REG_CONFIG, cfg);
      cmd(CODE_ROUND_ALL, 4'h0, 1'h0, 1'h0, 40'h0, rv);
      `CHK("oneSlotReply", 1'h1, rv)
      `CHK("tagType", cfg[0], reply.tagType)
      `CHK("battery", cfg[0] & cfg[1], reply.battery)
      `CHK("pageHead", {4'h0, 8'(32 * (i + 1))}, {reply.flags, reply.isError, reply.suidFlag, reply.payloadBits})
      if (i == 3) `CHK("page", user, reply.payload)
      rti();
      `CHK("collisionKey", {reply.signature, reply.idByte}, i_interrogator_model.collisionKey)
    end
    cmd(CODE_ROUND_ALL, 4'h8, 1'h0, 1'h0, 40'h0, rv);
    `CHK("suidHead", {1'h1, 1'h1, SHORT_UNIQUE_IDENTIFIER_BITS, sfid}, {rv, reply.suidFlag, reply.payloadBits, reply.idByte})
    `CHK("short_unique_identifier", short_unique_identifier, reply.payload[39:0])
    rti();
    wr(REG_CONFIG, cfg & 32'hffff_fffb);
    cmd(CODE_ROUND_ALL, 4'h0, 1'h0, 1'h0, 40'h0, rv);
    `CHK("noMemory", {SHORT_UNIQUE_IDENTIFIER_BITS, short_unique_identifier}, {reply.payloadBits, reply.payload[39:0]})
    rti();
    wr(REG_CONFIG, cfg);
    cmd(CODE_ROUND_ALL, 4'h0, 1'h1, 1'h0, 40'h0, rv);
    `CHK("errFrame", 1'h0, rv)
    rd(REG_STATUS, st);
    `CHK("errState", 3'h0, st[2:0])
    // Random round sizes; the first start is from ready, later ones re-pick while live
    for (int k = 0; k < 8; k++) begin
      size = $urandom_range(7, 0);
      cmd(CODE_ROUND_ALL, 4'(size), 1'h0, 1'h0, 40'h0, rv);
      rd(REG_STATUS, st);
      ch = st[15:12];
      `CHK("roundState", 15'h0b, {st[31:24], st[11:8], st[2:0]})
      `CHK("slotRange", 1'h1, ch >= 1 && ch <= (size == 0 ? 1 : size))
      `CHK("firstSlot", ch == 1, rv)
      for (int c = 2; c <= ch; c++) begin
        cmd(CODE_SLOT_CLOSE, 4'h0, 1'h0, 1'h0, 40'h0, rv);
        `CHK("slotReply", c == ch, rv)
      end
    end
    rti();
    cmd(CODE_ROUND_ALL, 4'h0, 1'h0, 1'h0, 40'h0, rv);
    rd(REG_RANDOM, q);
    // Acknowledge with the signature the tag sent; the generator has moved on since
    sig = reply.signature;
    cmd(CODE_STANDBY, sig, 1'h0, 1'h0, 40'h0, rv);
    rd(REG_STATUS, st);
    `CHK("selected", 3'h2, st[2:0])
    cmd(6'($urandom_range(63, 11)), 4'h0, 1'h0, 1'h0, 40'h0, rv);
    `CHK("unsupSel", {1'h1, 1'h1, ERR_UNSUPPORTED, 2'h1}, {rv, reply.isError, reply.errCode, reply.flags})
    cmd(CODE_ROUND_ALL, 4'h0, 1'h0, 1'h0, 40'h0, rv);
    rd(REG_STATUS, st);
    `CHK("selToQuiet", 5'h09, {rv, st[3:0]})
    cmd(CODE_ROUND_ALL, 4'h0, 1'h0, 1'h0, 40'h0, rv);
    rd(REG_STATUS, st);
    `CHK("quietStays", 5'h09, {rv, st[3:0]})
    cmd(6'h3f, 4'h0, 1'h0, 1'h1, ~short_unique_identifier, rv);
    `CHK("unsupOther", 1'h0, rv)
    cmd(6'h3f, 4'h0, 1'h0, 1'h1, short_unique_identifier, rv);
    `CHK("unsupSuid", {1'h1, ERR_UNSUPPORTED}, {rv, reply.errCode})
    rti();
    conclude();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    nMismatch++;
    conclude();
  end
endmodule : testbench
